// ===== verilog/lpm_pkg.sv
// shared constants and types for the lcd pointer, area and mode setup block
// assumes one 20 mhz clock and a host that sends operands before each command
package lpm_pkg;

   // host port addresses
   localparam logic [1:0] PORT_DATA     = 2'h0;
   localparam logic [1:0] PORT_CMD      = 2'h1;
   localparam logic [1:0] PORT_MODE     = 2'h2;

   // status byte, both ready flags always set since the block never stalls
   localparam int         STAT_CMD_RDY_BIT  = 0;
   localparam int         STAT_DATA_RDY_BIT = 1;
   localparam logic [7:0] STATUS_VALUE      = 8'h03;

   // command codes
   localparam logic [7:0] CMD_CURSOR    = 8'h21;
   localparam logic [7:0] CMD_OFFSET    = 8'h22;
   localparam logic [7:0] CMD_ADDR_PTR  = 8'h24;
   localparam logic [7:0] CMD_TEXT_HOME = 8'h40;
   localparam logic [7:0] CMD_TEXT_AREA = 8'h41;
   localparam logic [7:0] CMD_GFX_HOME  = 8'h42;
   localparam logic [7:0] CMD_GFX_AREA  = 8'h43;
   localparam logic [3:0] CMD_MODE_NIB  = 4'h8;
   localparam int         MODE_CG_BIT   = 3;

   // field widths
   localparam int COL_BITS    = 7;
   localparam int ROW_BITS    = 5;
   localparam int OFFSET_BITS = 5;
   localparam int ROW_HALF_BIT = 4;

   // reset values
   localparam logic [15:0] ADDR_RESET  = 16'h0000;
   localparam logic [7:0]  WIDTH_RESET = 8'h00;

   // visible columns per column select pin pair {b, a}
   localparam logic [6:0] VIS_COLS_LL = 7'h28;
   localparam logic [6:0] VIS_COLS_LH = 7'h40;
   localparam logic [6:0] VIS_COLS_HL = 7'h50;
   localparam logic [6:0] VIS_COLS_HH = 7'h20;

   typedef enum logic [2:0] {
      COMB_OR   = 3'h0,
      COMB_EXOR = 3'h1,
      COMB_AND  = 3'h3,
      COMB_ATTR = 3'h4
   } lpm_combine_e;

   // operand count since the last command
   typedef enum logic [2:0] {
      OPC_NONE = 3'b001,
      OPC_ONE  = 3'b010,
      OPC_TWO  = 3'b100
   } lpm_opc_e;

   typedef struct packed {
      logic         ext_cg;
      lpm_combine_e combine;
   } lpm_mode_s;

   typedef struct packed {
      logic [7:0] d1;
      logic [7:0] d2;
   } lpm_operands_s;

   typedef struct packed {
      logic known;
      logic blink;
      logic reverse;
      logic inhibit;
   } lpm_attr_s;

   localparam lpm_mode_s MODE_RESET = '{ext_cg: 1'b0, combine: COMB_OR};

   // low byte first, high byte second
   function automatic logic [15:0] lpm_word(input lpm_operands_s ops);
      return {ops.d2, ops.d1};
   endfunction : lpm_word

endpackage : lpm_pkg

// ===== verilog/lpm_attr_decode.sv
// registered decoder for one text attribute byte
// assumes the byte comes from logic on the same clock
`timescale 1ns/10ps
module lpm_attr_decode
   import lpm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] attr_byte,
   output lpm_attr_s       attr
);

   lpm_attr_s attr_reg;
   lpm_attr_s attr_next;

   always_comb begin
      // upper nibble is ignored, d3 is blink
      attr_next.blink   = attr_byte[3];                            // see R20
      attr_next.known   = 1'b1;
      attr_next.reverse = 1'b0;
      attr_next.inhibit = 1'b0;
      case (attr_byte[2:0])                                        // see R20
         3'h0: begin
         end
         3'h5: begin
            attr_next.reverse = 1'b1;
         end
         3'h3: begin
            attr_next.inhibit = 1'b1;
         end
         default: begin
            attr_next.known = 1'b0;
            attr_next.blink = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         attr_reg <= '0;
      end else begin
         attr_reg <= attr_next;
      end
   end

   assign attr = attr_reg;

endmodule : lpm_attr_decode

// ===== verilog/lpm_setup.sv
// command loaded pointer, area and mode setup of a text/graphic lcd controller
// assumes a host that writes operands to the data port, then a command code
// Summary of operation
// R1: host sends operands first; last two kept
// R2: host checks both ready flags before commands
// R3: only cursor command moves the cursor
// R4: cursor column seven bits, row five bits
// R5: dual scan splits rows into screen halves
// R6: offset command loads five bit pattern offset
// R7: pattern address is offset, code, dot row
// R8: internal mode upper codes use external ram
// R9: address pointer command loads low then high
// R10: text home command loads base address
// R11: text area command loads text line width
// R12: graphic home command loads base address
// R13: graphic area command loads graphic width
// R14: both column selects high shows 32 columns
// R15: matching width gives contiguous line addresses
// R16: mode set picks combination and generator
// R17: mode holds until next mode set
// R18: attribute mode reads graphic area, hides graphics
// R19: host enables text and graphics for attributes
// R20: attribute low nibble decodes display effect
// R21: each register changes only by its command
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/10ps
module lpm_setup
   import lpm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [1:0]  bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic [7:0]       bus_rdata,
   input  wire logic        column_sel_a,
   input  wire logic        column_sel_b,
   input  wire logic        dual_scan,
   input  wire logic [4:0]  line_index,
   input  wire logic [7:0]  char_code,
   input  wire logic [2:0]  dot_row,
   input  wire logic [7:0]  attr_byte,
   input  wire logic [15:0] text_char_addr,
   output logic [6:0]       cursor_col,
   output logic [4:0]       cursor_row,
   output logic [3:0]       cursor_row_scan,
   output logic             cursor_lower_half,
   output logic [4:0]       pattern_offset,
   output logic [15:0]      ram_addr_pointer,
   output logic [15:0]      text_base_addr,
   output logic [7:0]       text_line_width,
   output logic [15:0]      graphic_base_addr,
   output logic [7:0]       graphic_line_width,
   output lpm_mode_s        mode,
   output logic             graphic_shown,
   output logic [6:0]       hw_visible_columns,
   output logic             text_contiguous,
   output logic             graphic_contiguous,
   output logic [15:0]      text_line_start,
   output logic [15:0]      graphic_line_start,
   output logic [15:0]      pattern_addr,
   output logic             use_builtin_rom,
   output logic [15:0]      attr_addr,
   output lpm_attr_s        attr
);

   // pin synchronisers {dual, b, a}
   logic [2:0]    pin_meta_reg;
   logic [2:0]    pin_sync_reg;

   // operand capture
   logic [7:0]    older_reg, older_next;
   logic [7:0]    newer_reg, newer_next;
   lpm_opc_e      opc_reg, opc_next;
   lpm_operands_s ops;

   // setup registers
   logic [6:0]    col_reg, col_next;
   logic [4:0]    row_reg, row_next;
   logic [4:0]    offset_reg, offset_next;
   logic [15:0]   ptr_reg, ptr_next;
   logic [15:0]   tbase_reg, tbase_next;
   logic [7:0]    tw_reg, tw_next;
   logic [15:0]   gbase_reg, gbase_next;
   logic [7:0]    gw_reg, gw_next;
   lpm_mode_s     mode_reg, mode_next;
   logic [7:0]    rdata_reg, rdata_next;

   // derived display values
   logic [3:0]    row_scan_reg, row_scan_next;
   logic          lower_half_reg, lower_half_next;
   logic          gshown_reg, gshown_next;
   logic [6:0]    vis_reg, vis_next;
   logic          tcont_reg, tcont_next;
   logic          gcont_reg, gcont_next;
   logic [15:0]   tstart_reg, tstart_next;
   logic [15:0]   gstart_reg, gstart_next;
   logic [15:0]   paddr_reg, paddr_next;
   logic          rom_reg, rom_next;
   logic [15:0]   aaddr_reg, aaddr_next;

   logic          cmd_wr, data_wr;

   assign cmd_wr  = bus_wr && (bus_addr == PORT_CMD);
   assign data_wr = bus_wr && (bus_addr == PORT_DATA);

   function automatic logic [6:0] vis_cols(input logic [1:0] sel);
      case (sel)
         2'b00:   return VIS_COLS_LL;
         2'b01:   return VIS_COLS_LH;
         2'b10:   return VIS_COLS_HL;
         default: return VIS_COLS_HH;
      endcase
   endfunction : vis_cols

   // operands as seen by a command: last one or last two bytes
   always_comb begin
      ops = '0;
      case (opc_reg)
         OPC_TWO: ops = '{d1: older_reg, d2: newer_reg};          // see R1
         OPC_ONE: ops.d1 = newer_reg;
         default: ops = '0;
      endcase
   end

   // command interpreter
   always_comb begin
      older_next = older_reg;
      newer_next = newer_reg;
      opc_next   = opc_reg;
      col_next   = col_reg;
      row_next   = row_reg;
      offset_next = offset_reg;
      ptr_next   = ptr_reg;
      tbase_next = tbase_reg;
      tw_next    = tw_reg;
      gbase_next = gbase_reg;
      gw_next    = gw_reg;
      mode_next  = mode_reg;
      if (data_wr) begin
         older_next = newer_reg;
         newer_next = bus_wdata;
         case (opc_reg)
            OPC_NONE: opc_next = OPC_ONE;
            default:  opc_next = OPC_TWO;
         endcase
      end
      if (cmd_wr) begin
         opc_next = OPC_NONE;
         case (bus_wdata)                                         // see R21
            CMD_CURSOR: begin
               col_next = ops.d1[COL_BITS-1:0];                   // see R3, R4
               row_next = ops.d2[ROW_BITS-1:0];                   // see R4
            end
            CMD_OFFSET: begin
               offset_next = ops.d1[OFFSET_BITS-1:0];             // see R6
            end
            CMD_ADDR_PTR: begin
               ptr_next = lpm_word(ops);                          // see R9
            end
            CMD_TEXT_HOME: begin
               tbase_next = lpm_word(ops);                        // see R10
            end
            CMD_TEXT_AREA: begin
               tw_next = ops.d1;                                  // see R11
            end
            CMD_GFX_HOME: begin
               gbase_next = lpm_word(ops);                        // see R12
            end
            CMD_GFX_AREA: begin
               gw_next = ops.d1;                                  // see R13
            end
            default: begin
               if (bus_wdata[7:4] == CMD_MODE_NIB) begin          // see R16, R17
                  mode_next.ext_cg = bus_wdata[MODE_CG_BIT];
                  case (bus_wdata[2:0])
                     COMB_OR, COMB_EXOR, COMB_AND, COMB_ATTR: begin
                        mode_next.combine = lpm_combine_e'(bus_wdata[2:0]);
                     end
                     default: begin
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // read port: data stands only in the cycle after the strobe
   always_comb begin
      rdata_next = 8'h00;
      if (bus_rd) begin
         case (bus_addr)
            PORT_CMD:  rdata_next = STATUS_VALUE;                 // see R2
            PORT_MODE: rdata_next = {4'h0, mode_reg};
            default:   rdata_next = 8'h00;
         endcase
      end
   end

   // display address and mode derivation
   always_comb begin
      row_scan_next   = row_reg[3:0];                             // see R5
      lower_half_next = pin_sync_reg[2] && row_reg[ROW_HALF_BIT]; // see R5
      gshown_next     = (mode_reg.combine != COMB_ATTR);          // see R18
      vis_next        = vis_cols(pin_sync_reg[1:0]);              // see R14
      tcont_next      = (tw_reg == {1'b0, vis_reg});              // see R15
      gcont_next      = (gw_reg == {1'b0, vis_reg});              // see R15
      tstart_next     = tbase_reg + ({8'h00, tw_reg} * {11'h000, line_index}); // see R11
      gstart_next     = gbase_reg + ({8'h00, gw_reg} * {11'h000, line_index}); // see R13
      paddr_next      = {offset_reg, char_code, dot_row};         // see R7
      rom_next        = !mode_reg.ext_cg && !char_code[7];        // see R8
      aaddr_next      = gbase_reg + (text_char_addr - tbase_reg); // see R18
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_meta_reg   <= 3'h0;
         pin_sync_reg   <= 3'h0;
         older_reg      <= 8'h00;
         newer_reg      <= 8'h00;
         opc_reg        <= OPC_NONE;
         col_reg        <= 7'h00;
         row_reg        <= 5'h00;
         offset_reg     <= 5'h00;
         ptr_reg        <= ADDR_RESET;
         tbase_reg      <= ADDR_RESET;
         tw_reg         <= WIDTH_RESET;
         gbase_reg      <= ADDR_RESET;
         gw_reg         <= WIDTH_RESET;
         mode_reg       <= MODE_RESET;
         rdata_reg      <= 8'h00;
         row_scan_reg   <= 4'h0;
         lower_half_reg <= 1'b0;
         gshown_reg     <= 1'b1;
         vis_reg        <= VIS_COLS_LL;
         tcont_reg      <= 1'b0;
         gcont_reg      <= 1'b0;
         tstart_reg     <= ADDR_RESET;
         gstart_reg     <= ADDR_RESET;
         paddr_reg      <= ADDR_RESET;
         rom_reg        <= 1'b0;
         aaddr_reg      <= ADDR_RESET;
      end else begin
         pin_meta_reg   <= {dual_scan, column_sel_b, column_sel_a};
         pin_sync_reg   <= pin_meta_reg;
         older_reg      <= older_next;
         newer_reg      <= newer_next;
         opc_reg        <= opc_next;
         col_reg        <= col_next;
         row_reg        <= row_next;
         offset_reg     <= offset_next;
         ptr_reg        <= ptr_next;
         tbase_reg      <= tbase_next;
         tw_reg         <= tw_next;
         gbase_reg      <= gbase_next;
         gw_reg         <= gw_next;
         mode_reg       <= mode_next;
         rdata_reg      <= rdata_next;
         row_scan_reg   <= row_scan_next;
         lower_half_reg <= lower_half_next;
         gshown_reg     <= gshown_next;
         vis_reg        <= vis_next;
         tcont_reg      <= tcont_next;
         gcont_reg      <= gcont_next;
         tstart_reg     <= tstart_next;
         gstart_reg     <= gstart_next;
         paddr_reg      <= paddr_next;
         rom_reg        <= rom_next;
         aaddr_reg      <= aaddr_next;
      end
   end

   lpm_attr_decode u_attr (
      .clk       (clk),
      .rst       (rst),
      .attr_byte (attr_byte),
      .attr      (attr)
   );

   assign bus_rdata          = rdata_reg;
   assign cursor_col         = col_reg;
   assign cursor_row         = row_reg;
   assign cursor_row_scan    = row_scan_reg;
   assign cursor_lower_half  = lower_half_reg;
   assign pattern_offset     = offset_reg;
   assign ram_addr_pointer   = ptr_reg;
   assign text_base_addr     = tbase_reg;
   assign text_line_width    = tw_reg;
   assign graphic_base_addr  = gbase_reg;
   assign graphic_line_width = gw_reg;
   assign mode               = mode_reg;
   assign graphic_shown      = gshown_reg;
   assign hw_visible_columns = vis_reg;
   assign text_contiguous    = tcont_reg;
   assign graphic_contiguous = gcont_reg;
   assign text_line_start    = tstart_reg;
   assign graphic_line_start = gstart_reg;
   assign pattern_addr       = paddr_reg;
   assign use_builtin_rom    = rom_reg;
   assign attr_addr          = aaddr_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_cursor_load: assert property (cmd_wr && bus_wdata == CMD_CURSOR |=> // see R3
      {cursor_col, cursor_row} == $past({ops.d1[6:0], ops.d2[4:0]})) else $error("cursor unset");
   a_cursor_hold: assert property (!(cmd_wr && bus_wdata == CMD_CURSOR) |=> // see R3
      $stable(cursor_col) && $stable(cursor_row)) else $error("cursor moved");
   a_offset_load: assert property (cmd_wr && bus_wdata == CMD_OFFSET |=> // see R6
      pattern_offset == $past(ops.d1[4:0])) else $error("offset not loaded");
   a_ptr_load: assert property (cmd_wr && bus_wdata == CMD_ADDR_PTR |=> // see R9
      ram_addr_pointer == {$past(ops.d2), $past(ops.d1)}) else $error("pointer not loaded");
   a_home_hold: assert property (!(cmd_wr && bus_wdata == CMD_TEXT_HOME) |=> // see R21
      $stable(text_base_addr)) else $error("text base changed");
   a_gfx_home: assert property (cmd_wr && bus_wdata == CMD_GFX_HOME |=> // see R12
      graphic_base_addr == {$past(ops.d2), $past(ops.d1)}) else $error("graphic base unset");
   a_width_load: assert property (cmd_wr && bus_wdata == CMD_TEXT_AREA ##2 1'b1 |=> // see R11
      text_line_start == 16'($past(text_base_addr) + $past(line_index) * $past(text_line_width)))
      else $error("text line start wrong");
   a_mode_hold: assert property (!(cmd_wr && bus_wdata[7:4] == CMD_MODE_NIB) |=> // see R17
      $stable(mode)) else $error("mode changed without mode set");
   a_pattern_addr: assert property (1'b1 |=> // see R7
      pattern_addr == $past({offset_reg, char_code, dot_row})) else $error("pattern address bad");
   a_rom_select: assert property (char_code[7] || mode.ext_cg |=> !use_builtin_rom) // see R8
      else $error("rom used for external code");
   a_graphic_off: assert property (mode.combine == COMB_ATTR ##1 $stable(mode) // see R18
      |-> !graphic_shown) else $error("graphics shown in attribute mode");
   a_cols_high: assert property (pin_sync_reg[1:0] == 2'b11 |=> // see R14
      hw_visible_columns == 7'h20) else $error("visible columns not 32");
   a_status_read: assert property (bus_rd && bus_addr == PORT_CMD |=> // see R2
      bus_rdata == STATUS_VALUE ##1 bus_rdata == 8'h00 || $past(bus_rd)) else $error("bad status");

   c_cursor_cmd: cover property (data_wr ##1 data_wr ##1 cmd_wr && bus_wdata == CMD_CURSOR);
   c_attr_mode:  cover property (cmd_wr && bus_wdata[2:0] == 3'h4 && bus_wdata[7:4] == 4'h8);
   c_contig:     cover property (text_contiguous && graphic_contiguous);
   c_lower_half: cover property (cursor_lower_half);

endmodule : lpm_setup

// ===== sim/lpm_host.sv
// host processor model driving the setup block's register port
// assumes the block's clock; tasks are entered just after a rising edge
`timescale 1ns/10ps
module lpm_host
   import lpm_pkg::*;
(
   input  wire logic       clk,
   output logic [1:0]      bus_addr,
   output logic [7:0]      bus_wdata,
   output logic            bus_wr,
   output logic            bus_rd,
   input  wire logic [7:0] bus_rdata
);
   logic [7:0] status_seen;

   initial begin
      bus_addr = 2'h0;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      status_seen = 8'h00;
   end

   // idle write data shows the inverse so a stale byte is never mistaken for a live one
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr    <= 1'b0;
      bus_wdata <= ~d;
   endtask : wr

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd   <= 1'b0;
      #1;
      d = bus_rdata;
   endtask : rd

   // operands first, then a status check, then the code
   task automatic send(input logic [7:0] c, input logic [7:0] d1, input logic [7:0] d2,
                       input int n);
      if (n > 0) wr(PORT_DATA, d1);
      if (n > 1) wr(PORT_DATA, d2);
      rd(PORT_CMD, status_seen);
      wr(PORT_CMD, c);
   endtask : send
endmodule : lpm_host

// ===== sim/tb_lpm_setup.sv
// testbench for the lcd pointer, area and mode setup block
// assumes lpm_setup and the host model; one 20 mhz clock
`timescale 1ns/10ps
module tb_lpm_setup
   import lpm_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  bus_addr;
   logic [7:0]  bus_wdata, bus_rdata, char_code, attr_byte, text_line_width, graphic_line_width;
   logic        bus_wr, bus_rd, column_sel_a, column_sel_b, dual_scan;
   logic [4:0]  line_index, cursor_row, pattern_offset;
   logic [2:0]  dot_row;
   logic [15:0] text_char_addr, ram_addr_pointer, text_base_addr, graphic_base_addr;
   logic [15:0] text_line_start, graphic_line_start, pattern_addr, attr_addr;
   logic [6:0]  cursor_col, hw_visible_columns;
   logic [3:0]  cursor_row_scan;
   logic        cursor_lower_half, graphic_shown, text_contiguous, graphic_contiguous;
   logic        use_builtin_rom;
   lpm_mode_s   mode;
   lpm_attr_s   attr;
   int          num_errors = 0;
   int          n_checks = 0;
   logic [7:0]  b;

   always #25 clk = ~clk;

   lpm_host i_host (.clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata));

   lpm_setup i_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .column_sel_a(column_sel_a),
      .column_sel_b(column_sel_b), .dual_scan(dual_scan), .line_index(line_index),
      .char_code(char_code), .dot_row(dot_row), .attr_byte(attr_byte),
      .text_char_addr(text_char_addr), .cursor_col(cursor_col), .cursor_row(cursor_row),
      .cursor_row_scan(cursor_row_scan), .cursor_lower_half(cursor_lower_half),
      .pattern_offset(pattern_offset), .ram_addr_pointer(ram_addr_pointer),
      .text_base_addr(text_base_addr), .text_line_width(text_line_width),
      .graphic_base_addr(graphic_base_addr), .graphic_line_width(graphic_line_width),
      .mode(mode), .graphic_shown(graphic_shown), .hw_visible_columns(hw_visible_columns),
      .text_contiguous(text_contiguous), .graphic_contiguous(graphic_contiguous),
      .text_line_start(text_line_start), .graphic_line_start(graphic_line_start),
      .pattern_addr(pattern_addr), .use_builtin_rom(use_builtin_rom),
      .attr_addr(attr_addr), .attr(attr));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle

   task automatic t_reset();
      settle();
      chk(ram_addr_pointer, 16'h0000);
      chk({12'h000, mode}, 16'h0000);
      chk({15'h0000, graphic_shown}, 16'h0001);
      chk({9'h000, cursor_col}, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_cursor();
      i_host.send(CMD_CURSOR, 8'hcf, 8'hff, 2);
      settle();
      chk({9'h000, cursor_col}, 16'h004f);
      chk({11'h000, cursor_row}, 16'h001f);
      chk({12'h000, cursor_row_scan}, 16'h000f);
      chk({15'h0000, cursor_lower_half}, 16'h0001);
      chk({8'h00, i_host.status_seen}, {8'h00, STATUS_VALUE});
      // three operands: only the last two count
      i_host.wr(PORT_DATA, 8'h77);
      i_host.send(CMD_ADDR_PTR, 8'h34, 8'h12, 2);
      i_host.rd(PORT_DATA, b);
      chk({8'h00, b}, 16'h0000);
      i_host.wr(PORT_DATA, 8'h55);
      @(posedge clk);
      dual_scan <= 1'b0;
      settle();
      settle();
      chk(ram_addr_pointer, 16'h1234);
      chk(ram_addr_pointer, 16'h1234);
      chk({9'h000, cursor_col}, 16'h004f);
      chk({11'h000, cursor_row}, 16'h001f);
      chk({15'h0000, cursor_lower_half}, 16'h0000);
      $display("test cursor done");
   endtask : t_cursor

   task automatic t_offset();
      i_host.send(CMD_OFFSET, 8'h02, 8'h00, 2);
      @(posedge clk);
      char_code <= 8'h80;
      dot_row   <= 3'h3;
      settle();
      chk({11'h000, pattern_offset}, 16'h0002);
      chk(pattern_addr, 16'h1403);
      chk({15'h0000, use_builtin_rom}, 16'h0000);
      @(posedge clk);
      char_code <= 8'h7f;
      settle();
      chk({15'h0000, use_builtin_rom}, 16'h0001);
      i_host.send(8'h88, 8'h00, 8'h00, 0);
      settle();
      chk({15'h0000, use_builtin_rom}, 16'h0000);
      i_host.send(8'h80, 8'h00, 8'h00, 0);
      $display("test offset done");
   endtask : t_offset

   task automatic t_area();
      i_host.send(CMD_TEXT_HOME, 8'h00, 8'h10, 2);
      i_host.send(CMD_TEXT_AREA, 8'h20, 8'h00, 2);
      i_host.send(CMD_GFX_HOME, 8'h00, 8'h20, 2);
      i_host.send(CMD_GFX_AREA, 8'h14, 8'h00, 2);
      @(posedge clk);
      line_index     <= 5'h03;
      text_char_addr <= 16'h1005;
      settle();
      chk(text_base_addr, 16'h1000);
      chk({8'h00, text_line_width}, 16'h0020);
      chk(text_line_start, 16'h1060);
      chk(graphic_base_addr, 16'h2000);
      chk({8'h00, graphic_line_width}, 16'h0014);
      chk(graphic_line_start, 16'h203c);
      chk({9'h000, hw_visible_columns}, 16'h0020);
      chk({15'h0000, text_contiguous}, 16'h0001);
      chk({15'h0000, graphic_contiguous}, 16'h0000);
      chk(attr_addr, 16'h2005);
      chk(ram_addr_pointer, 16'h1234);
      chk({11'h000, pattern_offset}, 16'h0002);
      @(posedge clk);
      column_sel_a <= 1'b0;
      settle();
      settle();
      chk({9'h000, hw_visible_columns}, {9'h000, VIS_COLS_HL});
      chk({15'h0000, text_contiguous}, 16'h0000);
      @(posedge clk);
      column_sel_a <= 1'b1;
      $display("test area done");
   endtask : t_area

   task automatic t_mode();
      logic [2:0] low [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
      logic [7:0] c;
      for (int i = 0; i < 4; i++) begin
         c = {4'h8, i[0], low[i]};
         i_host.send(c, 8'h00, 8'h00, 0);
         settle();
         i_host.rd(PORT_MODE, b);
         chk({8'h00, b}, {12'h000, c[3:0]});
         chk({12'h000, mode}, {12'h000, c[3:0]});
         chk({15'h0000, graphic_shown}, {15'h0000, low[i] != 3'h4});
      end
      i_host.send(8'h9c, 8'h00, 8'h00, 0);
      i_host.send(CMD_CURSOR, 8'h01, 8'h02, 2);
      settle();
      chk({12'h000, mode}, 16'h000c);
      i_host.rd(2'h3, b);
      chk({8'h00, b}, 16'h0000);
      chk({9'h000, cursor_col}, 16'h0001);
      chk({11'h000, cursor_row}, 16'h0002);
      // combine code outside the table only moves the generator bit
      i_host.send(8'h82, 8'h00, 8'h00, 0);
      settle();
      chk({12'h000, mode}, 16'h0004);
      $display("test mode done");
   endtask : t_mode

   task automatic t_attr();
      logic [7:0] codes [7] = '{8'hf0, 8'hf5, 8'hf3, 8'hf8, 8'hfd, 8'hfb, 8'h07};
      logic [3:0] exp   [7] = '{4'h8, 4'ha, 4'h9, 4'hc, 4'he, 4'hd, 4'h0};
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         attr_byte <= codes[i];
         settle();
         chk({12'h000, attr}, {12'h000, exp[i]});
      end
      $display("test attr done");
   endtask : t_attr

   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   initial begin
      column_sel_a = 1'b1;
      column_sel_b = 1'b1;
      dual_scan = 1'b1;
      line_index = 5'h00;
      char_code = 8'h00;
      dot_row = 3'h0;
      attr_byte = 8'h00;
      text_char_addr = 16'h0000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_cursor();
      t_offset();
      t_area();
      t_mode();
      t_attr();
      test_done();
   end

   initial begin
      #(50 * 4000);
      num_errors++;
      test_done();
   end
endmodule : tb_lpm_setup
